// [core/vas_map.svh]
// Register offsets, field positions, reset values and timing figures of the
// voltage converter sequencer. Assumes it is included by bare name.
`ifndef VAS_MAP_SVH
`define VAS_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define VAS_OFS_AUX_VALUE 8'h21
`define VAS_OFS_SUPPLY_VALUE 8'h22
`define VAS_OFS_CONFIG_ONE 8'h40
`define VAS_OFS_STATUS 8'h41
`define VAS_OFS_AUX_LOW 8'h46
`define VAS_OFS_AUX_HIGH 8'h47
`define VAS_OFS_SUPPLY_LOW 8'h48
`define VAS_OFS_SUPPLY_HIGH 8'h49
`define VAS_OFS_CHAN_SELECT 8'h55
`define VAS_OFS_CONFIG_TWO 8'h73

// ****************************************************************
// Field positions
// ****************************************************************
`define VAS_CFG1_RESCALE_BIT 7
`define VAS_CFG1_TIMEOUT_DIS_BIT 6
`define VAS_CFG2_AVG_OFF_BIT 4
`define VAS_CFG2_BYPASS_BIT 5
`define VAS_CFG2_SINGLE_BIT 6
`define VAS_SEL_MSB 7
`define VAS_SEL_LSB 5
`define VAS_STAT_AUX_BIT 0
`define VAS_STAT_SUPPLY_BIT 1
`define VAS_STAT_LINE_BIT 7

// ****************************************************************
// Reset values and constants
// ****************************************************************
`define VAS_RST_VALUE 8'h00
`define VAS_RST_LOW_LIMIT 8'h00
`define VAS_RST_HIGH_LIMIT 8'hFF
`define VAS_RST_CONFIG 8'h00
`define VAS_RDATA_UNMAPPED 8'h00
`define VAS_AVG_LAST 4'hF
`define VAS_NOMINAL_CODE 10'h300

// ****************************************************************
// Timing
// ****************************************************************
`define VAS_CLK_PERIOD_NS 8
`define VAS_CONV_TIME_NS 700000

`endif

// [core/vas_pkg.sv]
// Types shared by the voltage converter sequencer.
// Assumes the map header supplies all numeric constants except the state and channel codes defined here.
package vas_pkg;

	// ****************************************************************
	// Sequencer states
	// ****************************************************************
	typedef enum logic [0:0] {
		VAS_ST_START = 1'b0,
		VAS_ST_SLOT = 1'b1
	} vas_state_t;

	// ****************************************************************
	// Converter channel codes
	// ****************************************************************
	typedef enum logic [2:0] {
		VAS_CH_NONE = 3'h0,
		VAS_CH_AUX = 3'h1,
		VAS_CH_SUPPLY = 3'h2,
		VAS_CH_REMOTE1 = 3'h5,
		VAS_CH_LOCAL = 3'h6,
		VAS_CH_REMOTE2 = 3'h7
	} vas_chan_t;

endpackage

// [core/vas_sequencer.sv]
// Conversion sequencer, averaging, limit check and register file around
// a 10-bit successive-approximation converter for two supply rails.
// Assumes a converter macro that answers each start with one done pulse
// and a 10-bit result, and a serial front-end that drives the register port.
`timescale 1ns/1ps
`include "vas_map.svh"

module vas_sequencer
	import vas_pkg::*;
#(
	parameter int CONV_CYCLES = `VAS_CONV_TIME_NS / `VAS_CLK_PERIOD_NS
) (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic conv_start_o,
	output logic [2:0] conv_channel_o,
	input wire logic conv_done_i,
	input wire logic [9:0] conv_result_i,
	output logic atten_bypass_o,
	output logic supply_rescale_o,
	output logic bus_timeout_disable_o,
	input wire logic alert_line_i,
	output logic alert_o,
	output logic alert_oe_o
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic out_of_limits(input logic [7:0] meas,
		input logic [7:0] low, input logic [7:0] high);
		out_of_limits = (meas < low) || (meas > high);
	endfunction

	function automatic vas_chan_t next_round_robin(input vas_chan_t cur);
		next_round_robin = (cur == VAS_CH_AUX) ? VAS_CH_SUPPLY : VAS_CH_AUX;
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	vas_state_t state_reg, state_next;
	logic [31:0] timer_reg, timer_next;
	vas_chan_t chan_reg, chan_next;
	logic [3:0] count_reg, count_next;
	logic [13:0] acc_reg, acc_next;
	logic [7:0] aux_value_reg, aux_value_next;
	logic [7:0] supply_value_reg, supply_value_next;
	logic [7:0] aux_low_reg, aux_low_next;
	logic [7:0] aux_high_reg, aux_high_next;
	logic [7:0] supply_low_reg, supply_low_next;
	logic [7:0] supply_high_reg, supply_high_next;
	logic [7:0] select_reg, select_next;
	logic [7:0] config_one_reg, config_one_next;
	logic [7:0] config_two_reg, config_two_next;
	logic [1:0] status_reg, status_next;
	logic [1:0] cond_reg, cond_next;
	logic [7:0] rdata_reg, rdata_next;
	logic alert_oe_reg, alert_oe_next;

	logic single_mode;
	logic avg_off;
	vas_chan_t active_chan;
	logic [13:0] sum;
	logic [7:0] meas;
	logic publish;
	logic aux_bad;
	logic supply_bad;

	assign single_mode = config_two_reg[`VAS_CFG2_SINGLE_BIT];
	assign avg_off = config_two_reg[`VAS_CFG2_AVG_OFF_BIT];
	// A select code outside the enumeration converts nothing useful here.
	assign active_chan = single_mode ?
		vas_chan_t'(select_reg[`VAS_SEL_MSB:`VAS_SEL_LSB]) : chan_reg;
	assign sum = acc_reg + {4'h0, conv_result_i};
	// Upper eight bits of the 10-bit code, or of the 10-bit average.
	assign meas = avg_off ? conv_result_i[9:2] : sum[13:6];
	assign publish = avg_off || (count_reg == `VAS_AVG_LAST);
	assign aux_bad = out_of_limits(meas, aux_low_reg, aux_high_reg);
	assign supply_bad = out_of_limits(meas, supply_low_reg, supply_high_reg);

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		chan_next = chan_reg;
		count_next = count_reg;
		acc_next = acc_reg;
		aux_value_next = aux_value_reg;
		supply_value_next = supply_value_reg;
		status_next = status_reg;
		cond_next = cond_reg;
		conv_start_o = 1'b0;

		if (reg_rd_i && (reg_addr_i == `VAS_OFS_STATUS)) begin
			// A bit whose violation persists stays set after the read.
			status_next = status_reg & cond_reg;
		end

		case (state_reg)
			VAS_ST_START: begin
				// Held low in reset so the converter never sees a start it cannot answer.
				conv_start_o = !reset_i;
				timer_next = '0;
				state_next = VAS_ST_SLOT;
			end
			VAS_ST_SLOT: begin
				// The slot length is fixed: a late done still lands in its own slot, and a
				// missing done only skips one sample instead of stalling the sequence.
				timer_next = timer_reg + 32'h1;
				if (timer_reg >= 32'(CONV_CYCLES - 1)) begin
					state_next = VAS_ST_START;
				end
				if (conv_done_i) begin
					if (publish) begin
						acc_next = '0;
						count_next = '0;
						case (active_chan)
							VAS_CH_AUX: begin
								aux_value_next = meas;
								cond_next[`VAS_STAT_AUX_BIT] = aux_bad;
								if (aux_bad) begin
									status_next[`VAS_STAT_AUX_BIT] = 1'b1;
								end
							end
							VAS_CH_SUPPLY: begin
								supply_value_next = meas;
								cond_next[`VAS_STAT_SUPPLY_BIT] = supply_bad;
								if (supply_bad) begin
									status_next[`VAS_STAT_SUPPLY_BIT] = 1'b1;
								end
							end
							default: begin
							end
						endcase
						if (!single_mode) begin
							chan_next = next_round_robin(chan_reg);
						end
					end else begin
						acc_next = sum;
						count_next = count_reg + 4'h1;
					end
				end
			end
			default: state_next = VAS_ST_START;
		endcase

		// Alert follows sticky status, so it drops only once a read cleared it.
		alert_oe_next = |status_next;
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			state_reg <= VAS_ST_START;
			timer_reg <= '0;
			chan_reg <= VAS_CH_AUX;
			count_reg <= '0;
			acc_reg <= '0;
			aux_value_reg <= `VAS_RST_VALUE;
			supply_value_reg <= `VAS_RST_VALUE;
			status_reg <= '0;
			cond_reg <= '0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			chan_reg <= chan_next;
			count_reg <= count_next;
			acc_reg <= acc_next;
			aux_value_reg <= aux_value_next;
			supply_value_reg <= supply_value_next;
			status_reg <= status_next;
			cond_reg <= cond_next;
		end
	end

	// ****************************************************************
	// Limit and configuration registers
	// ****************************************************************
	// Value and status registers are read-only; writes to them fall through
	// to the default branch and are dropped.
	always_comb begin
		aux_low_next = aux_low_reg;
		aux_high_next = aux_high_reg;
		supply_low_next = supply_low_reg;
		supply_high_next = supply_high_reg;
		select_next = select_reg;
		config_one_next = config_one_reg;
		config_two_next = config_two_reg;
		if (reg_wr_i) begin
			case (reg_addr_i)
				`VAS_OFS_AUX_LOW: aux_low_next = reg_wdata_i;
				`VAS_OFS_AUX_HIGH: aux_high_next = reg_wdata_i;
				`VAS_OFS_SUPPLY_LOW: supply_low_next = reg_wdata_i;
				`VAS_OFS_SUPPLY_HIGH: supply_high_next = reg_wdata_i;
				`VAS_OFS_CHAN_SELECT: select_next = reg_wdata_i;
				`VAS_OFS_CONFIG_ONE: config_one_next = reg_wdata_i;
				`VAS_OFS_CONFIG_TWO: config_two_next = reg_wdata_i;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			aux_low_reg <= `VAS_RST_LOW_LIMIT;
			aux_high_reg <= `VAS_RST_HIGH_LIMIT;
			supply_low_reg <= `VAS_RST_LOW_LIMIT;
			supply_high_reg <= `VAS_RST_HIGH_LIMIT;
			select_reg <= `VAS_RST_CONFIG;
			config_one_reg <= `VAS_RST_CONFIG;
			config_two_reg <= `VAS_RST_CONFIG;
		end else begin
			aux_low_reg <= aux_low_next;
			aux_high_reg <= aux_high_next;
			supply_low_reg <= supply_low_next;
			supply_high_reg <= supply_high_next;
			select_reg <= select_next;
			config_one_reg <= config_one_next;
			config_two_reg <= config_two_next;
		end
	end

	// ****************************************************************
	// Read data
	// ****************************************************************
	// Read data is captured so the serial front-end can shift it out over many
	// bus clocks while measurements keep changing underneath.
	always_comb begin
		rdata_next = rdata_reg;
		if (reg_rd_i) begin
			case (reg_addr_i)
				`VAS_OFS_AUX_VALUE: rdata_next = aux_value_reg;
				`VAS_OFS_SUPPLY_VALUE: rdata_next = supply_value_reg;
				`VAS_OFS_AUX_LOW: rdata_next = aux_low_reg;
				`VAS_OFS_AUX_HIGH: rdata_next = aux_high_reg;
				`VAS_OFS_SUPPLY_LOW: rdata_next = supply_low_reg;
				`VAS_OFS_SUPPLY_HIGH: rdata_next = supply_high_reg;
				`VAS_OFS_CHAN_SELECT: rdata_next = select_reg;
				`VAS_OFS_CONFIG_ONE: rdata_next = config_one_reg;
				`VAS_OFS_CONFIG_TWO: rdata_next = config_two_reg;
				`VAS_OFS_STATUS: rdata_next = {alert_line_i, 5'h00, status_reg};
				default: rdata_next = `VAS_RDATA_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			rdata_reg <= `VAS_RDATA_UNMAPPED;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// ****************************************************************
	// Alert driver
	// ****************************************************************
	// Registered so the open-drain enable cannot glitch during a status read.
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			alert_oe_reg <= 1'b0;
		end else begin
			alert_oe_reg <= alert_oe_next;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata_o = rdata_reg;
	assign conv_channel_o = active_chan;
	assign atten_bypass_o = config_two_reg[`VAS_CFG2_BYPASS_BIT];
	assign supply_rescale_o = config_one_reg[`VAS_CFG1_RESCALE_BIT];
	assign bus_timeout_disable_o = config_one_reg[`VAS_CFG1_TIMEOUT_DIS_BIT];
	// Open-drain line: only ever pulled low.
	assign alert_o = 1'b0;
	assign alert_oe_o = alert_oe_reg;

endmodule // vas_sequencer

// [tb/vas_sequencer_properties.sv]
// Concurrent checks on the sequencer ports, attached by bind.
// Assumes the conversion count is handed on from the bound instance.
`timescale 1ns/1ps
`include "vas_map.svh"
module vas_sequencer_properties #(
	parameter int CONV_CYCLES = 20
) (
	input logic clock_i,
	input logic reset_i,
	input logic [7:0] reg_addr_i,
	input logic reg_wr_i,
	input logic [7:0] reg_wdata_i,
	input logic reg_rd_i,
	input logic [7:0] reg_rdata_o,
	input logic conv_start_o,
	input logic [2:0] conv_channel_o,
	input logic conv_done_i,
	input logic [9:0] conv_result_i,
	input logic atten_bypass_o,
	input logic supply_rescale_o,
	input logic bus_timeout_disable_o,
	input logic alert_line_i,
	input logic alert_o,
	input logic alert_oe_o
);
	logic [31:0] gap_q;
	logic began_q;
	logic single_q;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	sequence cfg_wr(logic [7:0] a);
		reg_wr_i && reg_addr_i == a;
	endsequence
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			gap_q <= '0;
			began_q <= 1'b0;
			single_q <= 1'b0;
		end else begin
			gap_q <= conv_start_o ? '0 : gap_q + 1;
			began_q <= began_q | conv_start_o;
			if (reg_wr_i && reg_addr_i == `VAS_OFS_CONFIG_TWO) begin
				single_q <= reg_wdata_i[`VAS_CFG2_SINGLE_BIT];
			end
		end
	end
	start_period_a: assert property (began_q |->
		conv_start_o == (gap_q == CONV_CYCLES)) else $error("start out of period");
	bypass_follows_a: assert property (cfg_wr(8'h73) ##1 !cfg_wr(8'h73) |=>
		atten_bypass_o == $past(reg_wdata_i[5], 2)) else $error("bypass wrong");
	rescale_follows_a: assert property (cfg_wr(8'h40) ##1 !cfg_wr(8'h40) |=>
		{supply_rescale_o, bus_timeout_disable_o} == $past(reg_wdata_i[7:6], 2))
		else $error("config one outputs wrong");
	channel_hold_a: assert property (!single_q && !$past(single_q) && !$past(conv_done_i)
		&& !$past(reg_wr_i) |-> $stable(conv_channel_o)) else $error("channel moved");
	round_robin_a: assert property (!single_q && !$past(single_q)
		&& $past(conv_channel_o) inside {3'h1, 3'h2} && $changed(conv_channel_o)
		|-> conv_channel_o == ($past(conv_channel_o) == 3'h1 ? 3'h2 : 3'h1))
		else $error("channel order wrong");
	rdata_hold_a: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
		else $error("read data moved");
	unmapped_read_a: assert property (reg_rd_i && reg_addr_i == 8'h30 |=>
		reg_rdata_o == `VAS_RDATA_UNMAPPED) else $error("unmapped read not zero");
	alert_idle_a: assert property (alert_o == 1'b0) else $error("alert data high");
endmodule // vas_sequencer_properties
bind vas_sequencer vas_sequencer_properties #(.CONV_CYCLES(CONV_CYCLES)) i_props (.clock_i,
	.reset_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .conv_start_o,
	.conv_channel_o, .conv_done_i, .conv_result_i, .atten_bypass_o, .supply_rescale_o,
	.bus_timeout_disable_o, .alert_line_i, .alert_o, .alert_oe_o);

// [tb/vas_conv_model.sv]
// Behavioural converter: one done pulse and a code for each start.
// Assumes the bench sets the code and the answer delay in cycles.
`timescale 1ns/1ps
module vas_conv_model (
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic start_i,
	input wire logic [9:0] code_i,
	input wire logic [4:0] delay_i,
	output logic done_o,
	output logic [9:0] result_o
);
	logic [4:0] count_q;
	logic busy_q;
	logic [9:0] last_q;
	always_ff @(posedge clock_i) begin
		done_o <= 1'b0;
		if (reset_i) begin
			busy_q <= 1'b0;
			last_q <= 10'h000;
		end else if (start_i) begin
			busy_q <= 1'b1;
			count_q <= delay_i;
		end else if (busy_q && count_q == 5'h00) begin
			busy_q <= 1'b0;
			done_o <= 1'b1;
			last_q <= code_i;
		end else if (busy_q) begin
			count_q <= count_q - 5'h01;
		end
	end
	// Outside the done cycle the code is inverted, so a stale result is never read as valid.
	assign result_o = done_o ? last_q : ~last_q;
endmodule // vas_conv_model

// [tb/tb_top.sv]
// Self-checking bench: register accesses against a behavioural converter.
// Assumes a 20-cycle conversion time, so a 21-cycle slot, to keep the run short.
`timescale 1ns/1ps
`include "vas_map.svh"
module tb_top;
	localparam int SLOT = 21;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [7:0] reg_wdata_i = 8'h00;
	logic [7:0] reg_rdata_o, seen;
	logic conv_start_o, conv_done_i, atten_bypass_o, supply_rescale_o;
	logic bus_timeout_disable_o, alert_o, alert_oe_o, alert_line_i;
	logic [2:0] conv_channel_o;
	logic [9:0] conv_result_i;
	logic [9:0] code = 10'h300;
	logic [4:0] delay = 5'h00;
	int miscompares = 0;
	int check_count = 0;
	logic [7:0] ofs [7] = '{8'h21, 8'h22, 8'h46, 8'h47, 8'h48, 8'h49, 8'h30};
	logic [7:0] dflt [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00};
	logic [2:0] sel [5] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
	// The alert wire is pulled up and only ever pulled low.
	assign alert_line_i = alert_oe_o ? alert_o : 1'b1;
	initial begin
		forever #4 clock_i = ~clock_i;
	end
	vas_sequencer #(.CONV_CYCLES(20)) i_vas_sequencer (.clock_i, .reset_i, .reg_addr_i,
		.reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .conv_start_o, .conv_channel_o,
		.conv_done_i, .conv_result_i, .atten_bypass_o, .supply_rescale_o,
		.bus_timeout_disable_o, .alert_line_i, .alert_o, .alert_oe_o);
	vas_conv_model i_vas_conv_model (.clock_i, .reset_i, .start_i(conv_start_o), .code_i(code),
		.delay_i(delay), .done_o(conv_done_i), .result_o(conv_result_i));
	task automatic step(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		step(2);
	endtask
	task automatic rd(input logic [7:0] a);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		@(posedge clock_i);
		seen = reg_rdata_o;
	endtask
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		step(5000);
		miscompares++;
		print_verdict();
	end
	initial begin
		step(3);
		reset_i <= 1'b0;
		step(1);
		for (int i = 0; i < 7; i++) begin
			rd(ofs[i]);
			check(seen, dflt[i], "reset value");
		end
		$display("test reset values done");
		wr(`VAS_OFS_CONFIG_TWO, 8'h10);
		wr(`VAS_OFS_AUX_HIGH, 8'hD0);
		code <= 10'h343;
		delay <= 5'h12;
		step(3 * SLOT);
		rd(`VAS_OFS_AUX_VALUE);
		check(seen, 8'hD0, "aux value");
		rd(`VAS_OFS_STATUS);
		check(seen, 8'h80, "status at limit");
		code <= 10'h344;
		step(3 * SLOT);
		rd(`VAS_OFS_SUPPLY_VALUE);
		check(seen, 8'hD1, "supply value");
		rd(`VAS_OFS_STATUS);
		check(seen, 8'h01, "status over limit");
		check({7'h00, alert_oe_o}, 8'h01, "alert drive");
		wr(`VAS_OFS_AUX_HIGH, 8'hFF);
		step(3 * SLOT);
		check({7'h00, alert_oe_o}, 8'h01, "alert held");
		rd(`VAS_OFS_STATUS);
		step(2);
		rd(`VAS_OFS_STATUS);
		check(seen, 8'h80, "status released");
		check({7'h00, alert_oe_o}, 8'h00, "alert released");
		$display("test limits done");
		wr(`VAS_OFS_CONFIG_ONE, 8'h80);
		check({6'h00, supply_rescale_o, bus_timeout_disable_o}, 8'h02, "config one");
		wr(`VAS_OFS_CONFIG_ONE, 8'h40);
		check({6'h00, supply_rescale_o, bus_timeout_disable_o}, 8'h01, "config one");
		wr(`VAS_OFS_CONFIG_TWO, 8'h30);
		check({7'h00, atten_bypass_o}, 8'h01, "bypass");
		rd(`VAS_OFS_CONFIG_TWO);
		check(seen, 8'h30, "config two");
		delay <= 5'h00;
		for (int i = 0; i < 5; i++) begin
			wr(`VAS_OFS_CHAN_SELECT, {sel[i], 5'h00});
			wr(`VAS_OFS_CONFIG_TWO, 8'h50);
			step(2 * SLOT);
			check({5'h00, conv_channel_o}, {5'h00, sel[i]}, "channel");
		end
		wr(`VAS_OFS_CHAN_SELECT, 8'h20);
		wr(`VAS_OFS_CONFIG_TWO, 8'h40);
		code <= 10'h200;
		delay <= 5'h12;
		step(40 * SLOT);
		rd(`VAS_OFS_AUX_VALUE);
		check(seen, 8'h80, "averaged aux");
		rd(`VAS_OFS_SUPPLY_VALUE);
		check(seen, 8'hD1, "idle supply");
		$display("test modes done");
		print_verdict();
	end
endmodule // tb_top
